// ==== pkg/clt_pkg.sv ====
// constants and field layout of the configurable logic tile and pin cells
//
// Notes on behaviour
// - pin input reaches logic directly or through an edge flip-flop, per config bit
// - pin input flip-flops clear during configuration and while chip reset is low
// - all pin cells on one die edge share one input flip-flop clock
// - two config bits force the output buffer on, off, or under disable control
// - with disable control chosen, a high output_disable floats the pin
// - tile has inputs A to D, clock input K, outputs X and Y
// - sixteen-entry table gives any four-input function, delay independent of it
// - option 1: one four-variable function, F and G equal
// - option 2: F and G are independent three-variable functions of A-D and Q
// - option 3: B chooses between two three-variable tables, one merged output
// - storage element is an edge flip-flop or a transparent latch
// - storage clock or enable comes from K, C or G
// - a config bit inverts the chosen clock or enable
// - storage data input is always function F
// - separately enabled set and clear with chosen sources; clear wins
// - storage cleared while chip reset is low and during initialisation
// - unused storage element stays disabled, ignoring clock and data
// - X and Y each independently carry F, G or Q
// - global line feeds B and K; a per-tile bit picks it as clock
// - every tile and pin input picks one adjacent routing segment
// - configuration bits change only while configuring; readback anytime
package clt_pkg;
	localparam int DATA_W = 32;
	localparam int ADDR_W = 8;
	localparam int SYNC_STAGES = 3;
	localparam int ROUTE_SEGS = 4;
	localparam int MAX_PINS = 4;
	localparam int PIN_FIELD_W = 8;

	localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;
	localparam logic [ADDR_W-1:0] REG_LUT = 8'h08;
	localparam logic [ADDR_W-1:0] REG_TILE = 8'h0C;
	localparam logic [ADDR_W-1:0] REG_VARS = 8'h10;
	localparam logic [ADDR_W-1:0] REG_ROUTE = 8'h14;
	localparam logic [ADDR_W-1:0] REG_PIN = 8'h18;

	localparam logic [DATA_W-1:0] CTRL_RST = 32'h0000_0001;
	localparam logic [DATA_W-1:0] TILE_RST = 32'h0000_0001;
	localparam logic [DATA_W-1:0] ZERO_RST = 32'h0000_0000;

	localparam int CTRL_CFG_BIT = 0;

	localparam int TILE_FOPT_LSB = 0;
	localparam int TILE_USED_BIT = 2;
	localparam int TILE_LATCH_BIT = 3;
	localparam int TILE_CSRC_LSB = 4;
	localparam int TILE_CINV_BIT = 6;
	localparam int TILE_SET_EN_BIT = 7;
	localparam int TILE_SET_SRC_LSB = 8;
	localparam int TILE_CLR_EN_BIT = 10;
	localparam int TILE_CLR_SRC_LSB = 11;
	localparam int TILE_XSEL_LSB = 13;
	localparam int TILE_YSEL_LSB = 15;
	localparam int TILE_Q4_BIT = 17;

	localparam int VAR_CODE_W = 3;
	localparam int VARS_F_LSB = 0;
	localparam int VARS_G_LSB = 9;

	localparam int ROUTE_A_LSB = 0;
	localparam int ROUTE_B_LSB = 2;
	localparam int ROUTE_C_LSB = 4;
	localparam int ROUTE_D_LSB = 6;
	localparam int ROUTE_K_LSB = 8;
	localparam int ROUTE_BGBL_BIT = 10;
	localparam int ROUTE_KGBL_BIT = 11;

	localparam int PIN_OE_LSB = 0;
	localparam int PIN_INREG_BIT = 2;
	localparam int PIN_OSEL_LSB = 4;
	localparam int PIN_ODSEL_LSB = 6;

	localparam int STAT_Q_BIT = 0;
	localparam int STAT_X_BIT = 1;
	localparam int STAT_Y_BIT = 2;
	localparam int STAT_F_BIT = 3;
	localparam int STAT_G_BIT = 4;
	localparam int STAT_RST_BIT = 5;
	localparam int STAT_PIN_LSB = 8;

	typedef enum logic [1:0] {
		CLT_FOPT_ONE = 2'h1,
		CLT_FOPT_TWO = 2'h2,
		CLT_FOPT_THREE = 2'h3
	} clt_fopt_e;

	typedef enum logic [2:0] {
		CLT_VAR_A = 3'h0,
		CLT_VAR_B = 3'h1,
		CLT_VAR_C = 3'h2,
		CLT_VAR_D = 3'h3,
		CLT_VAR_Q = 3'h4
	} clt_var_e;

	typedef enum logic [1:0] {
		CLT_CSRC_K = 2'h0,
		CLT_CSRC_C = 2'h1,
		CLT_CSRC_G = 2'h2
	} clt_csrc_e;

	typedef enum logic [1:0] {
		CLT_OUT_F = 2'h0,
		CLT_OUT_G = 2'h1,
		CLT_OUT_Q = 2'h2
	} clt_osel_e;

	typedef enum logic [1:0] {
		CLT_OE_OFF = 2'h0,
		CLT_OE_ON = 2'h1,
		CLT_OE_TRI = 2'h2
	} clt_oe_e;
endpackage : clt_pkg

// ==== rtl/clt_lut.sv ====
// combinational function generator of the logic tile
`timescale 1ns/1ps
module clt_lut
	import clt_pkg::*;
(
	// table and options
	input wire logic [15:0] lut_table,
	input wire logic [1:0] fopt,
	input wire logic [8:0] f_vars,
	input wire logic [8:0] g_vars,
	input wire logic q4_sel,
	// variables
	input wire logic in_a,
	input wire logic in_b,
	input wire logic in_c,
	input wire logic in_d,
	input wire logic in_q,
	// functions
	output logic fn_f,
	output logic fn_g
);
	function automatic logic pick(input logic [2:0] code,
		input logic [4:0] v);
		logic r;
		r = 1'b0;
		if (code <= CLT_VAR_Q)
			r = v[code];
		return r;
	endfunction : pick

	logic [4:0] vin;
	logic [2:0] fidx;
	logic [2:0] gidx;
	logic [3:0] idx4;
	logic lo_t;
	logic hi_t;

	always_comb
	begin
		vin = {in_q, in_d, in_c, in_b, in_a};
		fidx = {pick(f_vars[6 +: 3], vin), pick(f_vars[3 +: 3], vin),
			pick(f_vars[0 +: 3], vin)};
		gidx = {pick(g_vars[6 +: 3], vin), pick(g_vars[3 +: 3], vin),
			pick(g_vars[0 +: 3], vin)};
		// fourth variable is Q or D, never both in one function
		idx4 = {(q4_sel ? in_q : in_d), in_c, in_b, in_a};
		lo_t = lut_table[{1'b0, fidx}];
		hi_t = lut_table[{1'b1, fidx}];
		// plain table lookup: delay does not depend on the contents
		unique case (fopt)
			CLT_FOPT_TWO:
			begin
				fn_f = lo_t;
				fn_g = lut_table[{1'b1, gidx}];
			end
			CLT_FOPT_THREE:
			begin
				fn_f = in_b ? hi_t : lo_t;
				fn_g = fn_f;
			end
			default:
			begin
				fn_f = lut_table[idx4];
				fn_g = fn_f;
			end
		endcase
	end
endmodule : clt_lut

// ==== rtl/clt_top.sv ====
// one logic tile and its pin cells behind an avalon-mm register slave
//
// The Avalon-MM interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module clt_top
	import clt_pkg::*;
#(
	parameter int NUM_PINS = 4
)
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic ce,
	// avalon-mm slave
	input wire logic [clt_pkg::ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [clt_pkg::DATA_W-1:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [clt_pkg::DATA_W-1:0] avs_readdata,
	output logic avs_waitrequest,
	// chip reset pin, low active
	input wire logic chip_rst_n,
	// routing segments and global line
	input wire logic [clt_pkg::ROUTE_SEGS-1:0] route_seg,
	input wire logic global_line,
	input wire logic edge_clk,
	// tile outputs
	output logic tile_x,
	output logic tile_y,
	// pin cells
	input wire logic [NUM_PINS-1:0] pad_in,
	output logic [NUM_PINS-1:0] pad_out,
	output logic [NUM_PINS-1:0] pad_oe_n,
	output logic [NUM_PINS-1:0] pin_i
);
	import clt_pkg::*;

	if (NUM_PINS < 1 || NUM_PINS > MAX_PINS)
	begin : g_bad_pins
		$error("clt_top: NUM_PINS must be 1 to 4");
	end

	typedef struct packed {
		logic wait_r;
		logic [DATA_W-1:0] rdata;
		logic [DATA_W-1:0] ctrl;
		logic [DATA_W-1:0] lut;
		logic [DATA_W-1:0] tile;
		logic [DATA_W-1:0] vars;
		logic [DATA_W-1:0] route;
		logic [DATA_W-1:0] pin;
		logic [SYNC_STAGES-1:0] rst_sync;
		logic rst_act;
		logic [SYNC_STAGES-1:0][NUM_PINS-1:0] pad_sync;
		logic [NUM_PINS-1:0] pad_filt;
		logic [NUM_PINS-1:0] in_ff;
		logic eclk_prev;
		logic sclk_prev;
		logic q;
		logic x;
		logic y;
		logic [NUM_PINS-1:0] pin_i;
		logic [NUM_PINS-1:0] pad_out;
		logic [NUM_PINS-1:0] pad_oe_n;
	} clt_state_s;

	clt_state_s st_reg;
	clt_state_s st_next;

	function automatic logic [DATA_W-1:0] merge(
		input logic [DATA_W-1:0] old_v,
		input logic [DATA_W-1:0] new_v,
		input logic [3:0] be);
		logic [DATA_W-1:0] r;
		r = old_v;
		for (int b = 0; b < 4; b++)
		begin
			if (be[b])
				r[b*8 +: 8] = new_v[b*8 +: 8];
		end
		return r;
	endfunction : merge

	// tile inputs picked from adjacent routing segments
	logic in_a;
	logic in_b;
	logic in_c;
	logic in_d;
	logic in_k;
	logic fn_f;
	logic fn_g;
	logic cfg_busy;
	logic clear_all;

	always_comb
	begin
		cfg_busy = st_reg.ctrl[CTRL_CFG_BIT];
		clear_all = cfg_busy | st_reg.rst_act;
		in_a = route_seg[st_reg.route[ROUTE_A_LSB +: 2]];
		in_b = st_reg.route[ROUTE_BGBL_BIT] ? global_line
			: route_seg[st_reg.route[ROUTE_B_LSB +: 2]];
		in_c = route_seg[st_reg.route[ROUTE_C_LSB +: 2]];
		in_d = route_seg[st_reg.route[ROUTE_D_LSB +: 2]];
		in_k = st_reg.route[ROUTE_KGBL_BIT] ? global_line
			: route_seg[st_reg.route[ROUTE_K_LSB +: 2]];
	end

	clt_lut u_lut (
		.lut_table(st_reg.lut[15:0]),
		.fopt(st_reg.tile[TILE_FOPT_LSB +: 2]),
		.f_vars(st_reg.vars[VARS_F_LSB +: 9]),
		.g_vars(st_reg.vars[VARS_G_LSB +: 9]),
		.q4_sel(st_reg.tile[TILE_Q4_BIT]),
		.in_a(in_a),
		.in_b(in_b),
		.in_c(in_c),
		.in_d(in_d),
		.in_q(st_reg.q),
		.fn_f(fn_f),
		.fn_g(fn_g)
	);

	// per pin cell output data, disable and buffer control
	wire [NUM_PINS-1:0] pin_o_w;
	wire [NUM_PINS-1:0] pin_od_w;
	wire [NUM_PINS-1:0] pin_oe_n_w;
	wire [NUM_PINS-1:0] pin_inreg_w;

	for (genvar i = 0; i < NUM_PINS; i++)
	begin : g_pin
		wire [PIN_FIELD_W-1:0] fld = st_reg.pin[i*PIN_FIELD_W +: PIN_FIELD_W];
		assign pin_o_w[i] = route_seg[fld[PIN_OSEL_LSB +: 2]];
		assign pin_od_w[i] = route_seg[fld[PIN_ODSEL_LSB +: 2]];
		assign pin_inreg_w[i] = fld[PIN_INREG_BIT];
		// unknown mode code keeps the buffer off
		assign pin_oe_n_w[i] =
			(fld[PIN_OE_LSB +: 2] == CLT_OE_ON) ? 1'b0 :
			(fld[PIN_OE_LSB +: 2] == CLT_OE_TRI) ? pin_od_w[i] :
			1'b1;
	end

	always_comb
	begin
		logic sclk;
		logic set_v;
		logic clr_v;
		logic eclk_rise;
		logic [DATA_W-1:0] rd;
		logic [DATA_W-1:0] wd;
		logic [3:0] srcs;
		sclk = 1'b0;
		set_v = 1'b0;
		clr_v = 1'b0;
		eclk_rise = 1'b0;
		rd = '0;
		wd = '0;
		srcs = {in_d, in_c, in_b, in_a};
		st_next = st_reg;

		// chip reset pin synchroniser and glitch filter
		st_next.rst_sync = {st_reg.rst_sync[1:0], ~chip_rst_n};
		if (st_reg.rst_sync[2] == st_reg.rst_sync[1])
			st_next.rst_act = st_reg.rst_sync[2];

		// pad input synchroniser: a change counts when stages 2 and 3 agree
		st_next.pad_sync[0] = pad_in;
		st_next.pad_sync[1] = st_reg.pad_sync[0];
		st_next.pad_sync[2] = st_reg.pad_sync[1];
		for (int i = 0; i < NUM_PINS; i++)
		begin
			if (st_reg.pad_sync[2][i] == st_reg.pad_sync[1][i])
				st_next.pad_filt[i] = st_reg.pad_sync[2][i];
		end

		// one edge clock for every pin cell on this die edge
		st_next.eclk_prev = edge_clk;
		eclk_rise = edge_clk & ~st_reg.eclk_prev;
		if (clear_all)
			st_next.in_ff = '0;
		else if (eclk_rise)
			st_next.in_ff = st_reg.pad_filt;
		for (int i = 0; i < NUM_PINS; i++)
		begin
			st_next.pin_i[i] = pin_inreg_w[i] ? st_reg.in_ff[i]
				: st_reg.pad_filt[i];
		end
		st_next.pad_out = pin_o_w;
		st_next.pad_oe_n = pin_oe_n_w;

		// storage element clock or enable, with polarity choice
		unique case (st_reg.tile[TILE_CSRC_LSB +: 2])
			CLT_CSRC_C: sclk = in_c;
			CLT_CSRC_G: sclk = fn_g;
			default: sclk = in_k;
		endcase
		sclk = sclk ^ st_reg.tile[TILE_CINV_BIT];
		st_next.sclk_prev = sclk;
		set_v = st_reg.tile[TILE_SET_EN_BIT]
			& srcs[st_reg.tile[TILE_SET_SRC_LSB +: 2]];
		clr_v = st_reg.tile[TILE_CLR_EN_BIT]
			& srcs[st_reg.tile[TILE_CLR_SRC_LSB +: 2]];
		// set and clear act as levels, not waiting for a clock edge
		if (clear_all || !st_reg.tile[TILE_USED_BIT])
			st_next.q = 1'b0;
		else if (clr_v)
			st_next.q = 1'b0;
		else if (set_v)
			st_next.q = 1'b1;
		else if (st_reg.tile[TILE_LATCH_BIT])
		begin
			if (sclk)
				st_next.q = fn_f;
		end
		else if (sclk && !st_reg.sclk_prev)
			st_next.q = fn_f;

		// output steering
		unique case (st_reg.tile[TILE_XSEL_LSB +: 2])
			CLT_OUT_G: st_next.x = fn_g;
			CLT_OUT_Q: st_next.x = st_reg.q;
			default: st_next.x = fn_f;
		endcase
		unique case (st_reg.tile[TILE_YSEL_LSB +: 2])
			CLT_OUT_G: st_next.y = fn_g;
			CLT_OUT_Q: st_next.y = st_reg.q;
			default: st_next.y = fn_f;
		endcase

		// readback is allowed at any time
		unique case (avs_address)
			REG_CTRL: rd = st_reg.ctrl;
			REG_STATUS:
			begin
				rd[STAT_Q_BIT] = st_reg.q;
				rd[STAT_X_BIT] = st_reg.x;
				rd[STAT_Y_BIT] = st_reg.y;
				rd[STAT_F_BIT] = fn_f;
				rd[STAT_G_BIT] = fn_g;
				rd[STAT_RST_BIT] = st_reg.rst_act;
				rd[STAT_PIN_LSB +: NUM_PINS] = st_reg.pin_i;
			end
			REG_LUT: rd = st_reg.lut;
			REG_TILE: rd = st_reg.tile;
			REG_VARS: rd = st_reg.vars;
			REG_ROUTE: rd = st_reg.route;
			REG_PIN: rd = st_reg.pin;
			default: rd = '0;
		endcase
		// readback mux already holds the addressed register's old value
		wd = merge(rd, avs_writedata, avs_byteenable);

		// one wait cycle, then a single ready cycle per request
		if (st_reg.wait_r)
		begin
			if (avs_read || avs_write)
			begin
				st_next.wait_r = 1'b0;
				st_next.rdata = rd;
			end
		end
		else
		begin
			st_next.wait_r = 1'b1;
			if (avs_write)
			begin
				if (avs_address == REG_CTRL)
					st_next.ctrl[CTRL_CFG_BIT] = wd[CTRL_CFG_BIT];
				// tile setup is frozen once loading has ended
				else if (cfg_busy)
				begin
					unique case (avs_address)
						REG_LUT: st_next.lut[15:0] = wd[15:0];
						REG_TILE: st_next.tile[17:0] = wd[17:0];
						REG_VARS: st_next.vars[17:0] = wd[17:0];
						REG_ROUTE: st_next.route[11:0] = wd[11:0];
						REG_PIN: st_next.pin[NUM_PINS*PIN_FIELD_W-1:0] =
							wd[NUM_PINS*PIN_FIELD_W-1:0];
						default: st_next.pin = st_reg.pin;
					endcase
				end
			end
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			st_reg <= '0;
			st_reg.wait_r <= 1'b1;
			st_reg.ctrl <= CTRL_RST;
			st_reg.tile <= TILE_RST;
			st_reg.lut <= ZERO_RST;
			st_reg.pad_oe_n <= '1;
		end
		else if (ce)
			st_reg <= st_next;
	end

	assign avs_readdata = st_reg.rdata;
	assign avs_waitrequest = st_reg.wait_r;
	assign tile_x = st_reg.x;
	assign tile_y = st_reg.y;
	assign pad_out = st_reg.pad_out;
	assign pad_oe_n = st_reg.pad_oe_n;
	assign pin_i = st_reg.pin_i;
endmodule : clt_top

// ==== tb/clt_user_model.sv ====
// far-side user logic: segments, global line, edge clock, pads
`timescale 1ns/1ps
module clt_user_model
	import clt_pkg::*;
(
	// clock
	input wire logic clk_sys,
	// levels the bench asks for
	input wire logic [3:0] seg_want,
	input wire logic glb_want,
	input wire logic eclk_want,
	input wire logic [3:0] pad_want,
	// tile side
	input wire logic [3:0] pad_out,
	input wire logic [3:0] pad_oe_n,
	output logic [3:0] route_seg,
	output logic global_line,
	output logic edge_clk,
	output logic [3:0] pad_in
);
	// user logic is registered, so nets move just after an edge
	always_ff @(posedge clk_sys)
	begin
		route_seg <= seg_want;
		global_line <= glb_want;
		edge_clk <= eclk_want;
	end
	// pad wire: tile wins while it drives
	always_comb
	begin
		for (int i = 0; i < 4; i++)
			pad_in[i] = pad_oe_n[i] ? pad_want[i] : pad_out[i];
	end
endmodule : clt_user_model

// ==== tb/clt_top_assertions.sv ====
// assertions on the tile's bus and pin outputs
`timescale 1ns/1ps
module clt_top_assertions
	import clt_pkg::*;
#(
	parameter int NUM_PINS = 4
)
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic ce,
	// bus
	input wire logic [clt_pkg::ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [clt_pkg::DATA_W-1:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	input wire logic avs_waitrequest,
	// tile and pins
	input wire logic [clt_pkg::ROUTE_SEGS-1:0] route_seg,
	input wire logic tile_x,
	input wire logic tile_y,
	input wire logic [NUM_PINS-1:0] pad_out,
	input wire logic [NUM_PINS-1:0] pad_oe_n,
	input wire logic [NUM_PINS-1:0] pin_i
);
	logic cfg;
	logic [7:0] pin0;
	logic [3:0] seg_d;
	logic acc;
	assign acc = avs_write && !avs_waitrequest && ce && avs_byteenable[0];
	// shadow of the configuring bit and pin 0 field
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			cfg <= 1'b1;
			pin0 <= 8'h00;
		end
		else if (acc && avs_address == REG_CTRL)
			cfg <= avs_writedata[CTRL_CFG_BIT];
		else if (acc && cfg && avs_address == REG_PIN)
			pin0 <= avs_writedata[7:0];
	end
	always_ff @(posedge clk_sys)
		seg_d <= route_seg;
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (sys_rst);
	a_wait_pulse: assert property (!avs_waitrequest && ce |=> avs_waitrequest)
		else $error("waitrequest low too long");
	a_req_answer: assert property ((avs_read || avs_write) && avs_waitrequest
		&& ce |=> !avs_waitrequest) else $error("request not answered");
	a_idle_quiet: assert property (!avs_read && !avs_write |=> avs_waitrequest)
		else $error("answer without request");
	a_rst_idle: assert property (disable iff (1'b0) sys_rst |=>
		avs_waitrequest && &pad_oe_n && !tile_x && !tile_y && pin_i == '0)
		else $error("outputs not idle after reset");
	// codes 0 and 3 both turn the buffer off
	a_oe_off: assert property (pin0[1] == pin0[0] |=> pad_oe_n[0])
		else $error("buffer driven while off");
	a_oe_on: assert property (!cfg && pin0[1:0] == CLT_OE_ON
		|=> !pad_oe_n[0]) else $error("buffer not driven while on");
	a_oe_tri: assert property (!cfg && pin0[1:0] == CLT_OE_TRI
		|=> pad_oe_n[0] == seg_d[pin0[7:6]])
		else $error("disable control not followed");
	a_out_data: assert property (!cfg && pin0[1] != pin0[0]
		|=> pad_out[0] == seg_d[pin0[5:4]]) else $error("wrong pad data");
	c_pin_wr: cover property (acc && avs_address == REG_PIN);
	c_tri_off: cover property (!cfg && pin0[1:0] == CLT_OE_TRI
		&& route_seg[pin0[7:6]]);
	c_read: cover property (avs_read && !avs_waitrequest);
endmodule : clt_top_assertions
bind clt_top clt_top_assertions #(.NUM_PINS(NUM_PINS)) i_chk (.clk_sys,
	.sys_rst, .ce, .avs_address, .avs_read, .avs_write, .avs_writedata,
	.avs_byteenable, .avs_waitrequest, .route_seg, .tile_x, .tile_y,
	.pad_out, .pad_oe_n, .pin_i);

// ==== tb/configurable_logic_tile_test.sv ====
// self-checking bench for the logic tile and pin cells
`timescale 1ns/1ps
module configurable_logic_tile_test;
	import clt_pkg::*;
	logic clk_sys = 1'b0;
	logic sys_rst = 1'b1;
	logic ce = 1'b1;
	logic chip_rst_n = 1'b1;
	logic [7:0] avs_address = 8'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic [3:0] seg_want = 4'h0;
	logic glb_want = 1'b0;
	logic eclk_want = 1'b0;
	logic [3:0] pad_want = 4'h0;
	logic [3:0] route_seg, pad_in, pad_out, pad_oe_n, pin_i;
	logic global_line, edge_clk, tile_x, tile_y;
	logic [31:0] t_lut [3] = '{32'h6996, 32'h8096, 32'hFE80};
	logic [31:0] t_vars [3] = '{32'h0, 32'h1A288, 32'hD0};
	logic [31:0] t_tile [3] = '{32'h8001, 32'h8002, 32'h3};
	int n_errors = 0;
	int checked = 0;
	clt_top #(.NUM_PINS(4)) i_dut (.clk_sys, .sys_rst, .ce, .avs_address,
		.avs_read, .avs_write, .avs_writedata, .avs_byteenable(4'hF),
		.avs_readdata, .avs_waitrequest, .chip_rst_n, .route_seg,
		.global_line, .edge_clk, .tile_x, .tile_y, .pad_in, .pad_out,
		.pad_oe_n, .pin_i);
	clt_user_model i_user (.clk_sys, .seg_want, .glb_want, .eclk_want,
		.pad_want, .pad_out, .pad_oe_n, .route_seg, .global_line,
		.edge_clk, .pad_in);
	initial
	begin
		forever #12.5 clk_sys = ~clk_sys;
	end
	task automatic stop_test();
		if (n_errors == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : stop_test
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("BAD %0t saw %h wanted %h", $time, seen, exp);
		end
	endtask : check
	task automatic bus(input logic wr, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		do
		begin
			@(posedge clk_sys);
			n++;
		end
		while (avs_waitrequest !== 1'b0 && n < 20);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge clk_sys);
		if (n >= 20)
		begin
			n_errors++;
			stop_test();
		end
	endtask : bus
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask : wr
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		check(q, e);
	endtask : rd_chk
	// every cfg call puts its write inside the configuring phase
	task automatic cfg(input logic [7:0] a, input logic [31:0] d);
		wr(REG_CTRL, 32'h1);
		wr(a, d);
		wr(REG_CTRL, 32'h0);
	endtask : cfg
	task automatic xq(input logic e);
		// chip reset needs sync, filter, q and x: about 6 cycles
		repeat (8) @(posedge clk_sys);
		check({31'h0, tile_x}, {31'h0, e});
	endtask : xq
	function automatic logic [1:0] fexp(input int o, input logic [3:0] v);
		logic m;
		m = v[1] ? (v[0] | v[2] | v[3]) : (v[0] & v[2] & v[3]);
		case (o)
			0: fexp = {^v, ^v};
			1: fexp = {^v[2:0], &v[3:1]};
			default: fexp = {m, m};
		endcase
	endfunction : fexp
	initial
	begin
		repeat (4) @(posedge clk_sys);
		sys_rst <= 1'b0;
		@(posedge clk_sys);
		rd_chk(REG_CTRL, CTRL_RST);
		rd_chk(REG_TILE, TILE_RST);
		rd_chk(REG_PIN, ZERO_RST);
		rd_chk(8'h40, ZERO_RST);
		// segments 0..3 feed A..D, K from the global line
		cfg(REG_ROUTE, 32'h8E4);
		cfg(REG_PIN, 32'h91);
		for (int v = 0; v < 16; v++)
		begin
			seg_want <= v[3:0];
			repeat (4) @(posedge clk_sys);
			check({pad_oe_n[0], pad_out[0]}, {1'b0, v[1]});
		end
		wr(REG_PIN, 32'h92);
		rd_chk(REG_PIN, 32'h91);
		cfg(REG_PIN, 32'h92);
		for (int v = 0; v < 16; v++)
		begin
			seg_want <= v[3:0];
			repeat (4) @(posedge clk_sys);
			check(pad_oe_n[0], v[2]);
		end
		pad_want <= 4'hA;
		cfg(REG_PIN, 32'h04040404);
		repeat (8) @(posedge clk_sys);
		check(pin_i, 4'h0);
		eclk_want <= 1'b1;
		repeat (8) @(posedge clk_sys);
		check(pin_i, 4'hA);
		eclk_want <= 1'b0;
		wr(REG_CTRL, 32'h1);
		repeat (2) @(posedge clk_sys);
		check(pin_i, 4'h0);
		cfg(REG_PIN, 32'h0);
		repeat (8) @(posedge clk_sys);
		check(pin_i, 4'hA);
		// loader never mixes Q and D in one function
		for (int o = 0; o < 3; o++)
		begin
			cfg(REG_LUT, t_lut[o]);
			cfg(REG_VARS, t_vars[o]);
			cfg(REG_TILE, t_tile[o]);
			for (int v = 0; v < 16; v++)
			begin
				seg_want <= v[3:0];
				repeat (4) @(posedge clk_sys);
				check({tile_x, tile_y}, fexp(o, v[3:0]));
			end
		end
		cfg(REG_LUT, 32'hAAAA);
		cfg(REG_VARS, 32'h0);
		cfg(REG_TILE, 32'h4005);
		seg_want <= 4'h1;
		xq(1'b0);
		glb_want <= 1'b1;
		xq(1'b1);
		seg_want <= 4'h0;
		xq(1'b1);
		chip_rst_n <= 1'b0;
		xq(1'b0);
		repeat (4) @(posedge clk_sys);
		chip_rst_n <= 1'b1;
		seg_want <= 4'h1;
		cfg(REG_TILE, 32'h4045);
		glb_want <= 1'b0;
		xq(1'b1);
		cfg(REG_TILE, 32'h400D);
		glb_want <= 1'b1;
		xq(1'b1);
		seg_want <= 4'h0;
		xq(1'b0);
		glb_want <= 1'b0;
		cfg(REG_TILE, 32'h4001);
		seg_want <= 4'h1;
		glb_want <= 1'b1;
		xq(1'b0);
		glb_want <= 1'b0;
		cfg(REG_TILE, 32'h4C85);
		seg_want <= 4'h3;
		xq(1'b0);
		seg_want <= 4'h1;
		xq(1'b1);
		stop_test();
	end
endmodule : configurable_logic_tile_test
